// file: hw/sgc_global_ctrl.v
// global forwarding and host-port control registers of the switch, behind a wishbone slave
// Notes on behaviour
// - with igmp snoop set, every igmp packet goes to the host-facing port, else normal forwarding.
// - with direct mode set, host-port ingress uses the preamble destination and skips lookup.
// - with pre-tag set, frames to the host port carry their ingress port number in the preamble.
// - with tag mask set and vlan enable clear, the low five vid bits select the egress ports.
// - sniff select 1 needs both source and destination to match, 0 needs either.
// - back pressure bit enables half-duplex back pressure on the host port.
// - duplex bit 1 runs the host port half duplex, 0 full duplex.
// - flow control bit enables full-duplex pause on the host port.
// - duplex, flow and speed bits load from their straps at reset, pulled down to 0.
// - null vid replacement bit swaps a null vid for the 12-bit port vid.
// - the 11-bit storm threshold is host-link bits [2:0] over the low rate byte.
// - the storm period is 50 ms at 100 Mbps and 500 ms at 10 Mbps.
// - the low rate byte resets to 0x4A and the high bits to zero.
// - vlan enable bit turns on 802.1q mode, once software has filled the vlan table.
//
// Register access over Wishbone was left to the implementer.
`timescale 1ns/10ps
`include "sgc_defines.vh"

module sgc_global_ctrl #(
  parameter PERIOD_100_CYC = `SGC_PERIOD_100_MS * `SGC_CLK_MHZ * 1000,
  parameter PERIOD_10_CYC = `SGC_PERIOD_10_MS * `SGC_CLK_MHZ * 1000,
  parameter CNT_W = 27
) (
  input wire clk_i,
  input wire rst_i,
  // wishbone classic slave
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [31:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  output reg err_o,
  // straps, sampled at reset
  input wire speed_strap_pin_i,
  input wire duplex_strap_pin_i,
  input wire flow_ctrl_strap_pin_i,
  // forwarding-plane decision inputs
  input wire igmp_pkt_i,
  input wire host_ingress_i,
  input wire [4:0] lookup_ports_i,
  input wire [4:0] preamble_ports_i,
  input wire [11:0] pkt_vid_i,
  input wire [11:0] port_vid_i,
  input wire sniff_src_match_i,
  input wire sniff_dst_match_i,
  input wire storm_block_i,
  input wire storm_port_10m_i,
  // forwarding-plane controls
  output reg vlan_en_o,
  output reg [4:0] egress_ports_o,
  output reg host_pretag_en_o,
  output reg sniff_hit_o,
  output reg host_bp_en_o,
  output reg host_half_dup_o,
  output reg host_flow_en_o,
  output reg host_speed_10_o,
  output reg [11:0] vid_out_o,
  output reg [10:0] storm_thresh_o,
  output reg storm_drop_o,
  output reg storm_period_o
);

  localparam [4:0] HOST_PORT_MASK = 5'h10;

  reg [7:0] fwd_q;
  reg [7:0] host_q;
  reg [7:0] storm_lo_q;
  reg [CNT_W-1:0] per_cnt_q;
  reg [10:0] blk_cnt_q;
  reg [10:0] thresh;

  wire [31:0] byte_idx = {2'h0, adr_i[31:2]};
  wire acc = cyc_i & stb_i & ~ack_o & ~err_o;
  wire wr = acc & we_i & sel_i[0];
  wire hit_fwd = byte_idx == {24'h0, `SGC_IDX_FWD_MODE};
  wire hit_host = byte_idx == {24'h0, `SGC_IDX_HOST_LINK};
  wire hit_lo = byte_idx == {24'h0, `SGC_IDX_STORM_LO};
  wire hit_fac = byte_idx == {24'h0, `SGC_IDX_FACTORY};
  wire mapped = hit_fwd | hit_host | hit_lo | hit_fac;

  // register writes; straps are caught while reset is held, which is synchronous
  always @(posedge clk_i) begin
    if (rst_i) begin
      fwd_q <= `SGC_FWD_RESET;
      host_q <= {1'b0, duplex_strap_pin_i, flow_ctrl_strap_pin_i, speed_strap_pin_i,
                 1'b0, `SGC_HOST_RESET_HI};
      storm_lo_q <= `SGC_STORM_LO_RESET;
    end else if (wr) begin
      // reserved bits 3:2 of the mode register stay zero
      if (hit_fwd)
        fwd_q <= dat_i[7:0] & `SGC_FWD_RW_MASK;
      if (hit_host)
        host_q <= dat_i[7:0];
      if (hit_lo)
        storm_lo_q <= dat_i[7:0];
    end
  end

  // one-cycle answer; unmapped addresses get err instead of ack
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
      dat_o <= 32'h0;
    end else begin
      ack_o <= acc & mapped;
      err_o <= acc & ~mapped;
      if (acc & ~we_i) begin
        if (hit_fwd)
          dat_o <= {24'h0, fwd_q};
        else if (hit_host)
          dat_o <= {24'h0, host_q};
        else if (hit_lo)
          dat_o <= {24'h0, storm_lo_q};
        else if (hit_fac)
          dat_o <= {24'h0, `SGC_FACTORY_VALUE};
        else
          dat_o <= 32'h0;
      end
    end
  end

  // forwarding decision, registered so outputs come from flip-flops
  always @(posedge clk_i) begin
    if (rst_i) begin
      egress_ports_o <= 5'h0;
      sniff_hit_o <= 1'b0;
      vid_out_o <= 12'h0;
    end else begin
      if (fwd_q[`SGC_FWD_IGMP_SNOOP] && igmp_pkt_i)
        egress_ports_o <= HOST_PORT_MASK;
      else if (fwd_q[`SGC_FWD_DIRECT] && host_ingress_i)
        egress_ports_o <= preamble_ports_i;
      else if (fwd_q[`SGC_FWD_TAG_MASK] && !fwd_q[`SGC_FWD_VLAN_EN])
        egress_ports_o <= pkt_vid_i[4:0];
      else
        egress_ports_o <= lookup_ports_i;
      if (fwd_q[`SGC_FWD_SNIFF_AND])
        sniff_hit_o <= sniff_src_match_i & sniff_dst_match_i;
      else
        sniff_hit_o <= sniff_src_match_i | sniff_dst_match_i;
      if (host_q[`SGC_HOST_NULL_VID] && pkt_vid_i == 12'h000)
        vid_out_o <= port_vid_i;
      else
        vid_out_o <= pkt_vid_i;
    end
  end

  // static controls follow the registers one cycle later
  always @(posedge clk_i) begin
    if (rst_i) begin
      vlan_en_o <= 1'b0;
      host_pretag_en_o <= 1'b0;
      host_bp_en_o <= 1'b0;
      host_half_dup_o <= 1'b0;
      host_flow_en_o <= 1'b0;
      host_speed_10_o <= 1'b0;
      storm_thresh_o <= 11'h0;
    end else begin
      vlan_en_o <= fwd_q[`SGC_FWD_VLAN_EN];
      host_pretag_en_o <= fwd_q[`SGC_FWD_PRETAG];
      host_bp_en_o <= host_q[`SGC_HOST_BP_EN];
      host_half_dup_o <= host_q[`SGC_HOST_HALF_DUP];
      host_flow_en_o <= host_q[`SGC_HOST_FLOW_EN];
      host_speed_10_o <= host_q[`SGC_HOST_SPEED_10];
      storm_thresh_o <= thresh;
    end
  end

  always @* begin
    thresh = {host_q[`SGC_HOST_RATE_HI_MSB:0], storm_lo_q};
  end

  // storm window: one counter, length picked by the port speed; a shared
  // counter is cheaper than one per port at the cost of a single port view
  always @(posedge clk_i) begin
    if (rst_i) begin
      per_cnt_q <= {CNT_W{1'b0}};
      blk_cnt_q <= 11'h0;
      storm_period_o <= 1'b0;
      storm_drop_o <= 1'b0;
    end else begin
      storm_period_o <= 1'b0;
      if ((storm_port_10m_i && per_cnt_q >= PERIOD_10_CYC[CNT_W-1:0] - 1'b1) ||
          (!storm_port_10m_i && per_cnt_q >= PERIOD_100_CYC[CNT_W-1:0] - 1'b1)) begin
        per_cnt_q <= {CNT_W{1'b0}};
        blk_cnt_q <= 11'h0;
        storm_period_o <= 1'b1;
        storm_drop_o <= 1'b0;
      end else begin
        per_cnt_q <= per_cnt_q + 1'b1;
        if (storm_block_i) begin
          if (blk_cnt_q >= thresh)
            storm_drop_o <= 1'b1;
          else
            blk_cnt_q <= blk_cnt_q + 1'b1;
        end
      end
    end
  end

endmodule

// file: hw/sgc_defines.vh
// register offsets, field positions, reset values and timing counts for the global control bank
`ifndef SGC_DEFINES_VH
`define SGC_DEFINES_VH

// byte offsets; the bank is reached as word index = offset, byte address = 4 * offset
`define SGC_IDX_FWD_MODE 8'h05
`define SGC_IDX_HOST_LINK 8'h06
`define SGC_IDX_STORM_LO 8'h07
`define SGC_IDX_FACTORY 8'h08

// forwarding_mode_control fields
`define SGC_FWD_VLAN_EN 7
`define SGC_FWD_IGMP_SNOOP 6
`define SGC_FWD_DIRECT 5
`define SGC_FWD_PRETAG 4
`define SGC_FWD_TAG_MASK 1
`define SGC_FWD_SNIFF_AND 0
`define SGC_FWD_RW_MASK 8'hF3
`define SGC_FWD_RESET 8'h00

// host_port_link_control fields
`define SGC_HOST_BP_EN 7
`define SGC_HOST_HALF_DUP 6
`define SGC_HOST_FLOW_EN 5
`define SGC_HOST_SPEED_10 4
`define SGC_HOST_NULL_VID 3
`define SGC_HOST_RATE_HI_MSB 2
`define SGC_HOST_RESET_HI 3'h0

// storm rate and factory byte
`define SGC_STORM_LO_RESET 8'h4A
`define SGC_FACTORY_VALUE 8'h00

// storm measurement periods
`define SGC_PERIOD_100_MS 50
`define SGC_PERIOD_10_MS 500
`define SGC_CLK_MHZ 250

`endif

// file: verif/sgc_global_ctrl_properties.sv
// bus handshake and control-output relations of the global control bank
`timescale 1ns/10ps
module sgc_global_ctrl_props (
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire ack_o,
  input wire err_o,
  input wire [31:0] dat_o,
  input wire sniff_src_match_i,
  input wire sniff_dst_match_i,
  input wire sniff_hit_o,
  input wire [11:0] pkt_vid_i,
  input wire [11:0] vid_out_o,
  input wire host_half_dup_o,
  input wire host_speed_10_o,
  input wire storm_period_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_take; cyc_i && stb_i && !ack_o && !err_o |=> ack_o || err_o; endproperty
  a_take: assert property (p_take) else $error("request not answered");
  property p_pulse; ack_o || err_o |=> !ack_o && !err_o; endproperty
  a_pulse: assert property (p_pulse) else $error("answer longer than one cycle");
  property p_excl; !(ack_o && err_o); endproperty
  a_excl: assert property (p_excl) else $error("ack and err together");
  property p_dat; ack_o |-> dat_o[31:8] == 24'h000000; endproperty
  a_dat: assert property (p_dat) else $error("upper read bits set");
  property p_both; sniff_src_match_i && sniff_dst_match_i |=> sniff_hit_o; endproperty
  a_both: assert property (p_both) else $error("double match not mirrored");
  property p_none; !sniff_src_match_i && !sniff_dst_match_i |=> !sniff_hit_o; endproperty
  a_none: assert property (p_none) else $error("mirror without match");
  property p_vid; pkt_vid_i != 12'h000 |=> vid_out_o == $past(pkt_vid_i); endproperty
  a_vid: assert property (p_vid) else $error("non-null vid altered");
  property p_cfg;
    !$past(ack_o) && !$past(rst_i) && !$past(rst_i, 2) |->
      $stable({host_half_dup_o, host_speed_10_o});
  endproperty
  a_cfg: assert property (p_cfg) else $error("link mode moved without access");
  c_ack: cover property (ack_o);
  c_err: cover property (err_o);
  c_per: cover property (storm_period_o);
endmodule

// file: verif/sgc_wb_host.sv
// classic wishbone master standing in for the management processor
`timescale 1ns/10ps
module sgc_wb_host (
  input wire clk_i,
  input wire ack_i,
  input wire err_i,
  input wire [31:0] dat_i,
  output logic cyc_o = 1'b0,
  output logic we_o = 1'b0,
  output logic [3:0] sel_o = 4'h0,
  output logic [31:0] adr_o = 32'h00000000,
  output logic [31:0] dat_o = 32'h00000000
);
  // r is {err,ack}; 00 means the wait ran out
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] wd,
    output logic [7:0] rd, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_o <= 1'b1;
    we_o <= w;
    sel_o <= 4'hF;
    adr_o <= {22'h000000, idx, 2'h0};
    dat_o <= {24'h000000, wd};
    do begin
      @(posedge clk_i);
      n++;
    end while (!(ack_i || err_i) && n < 50);
    rd = dat_i[7:0];
    r = {err_i, ack_i};
    cyc_o <= 1'b0;
    sel_o <= 4'h0;
  endtask
endmodule

// file: verif/tb_switch_global_control_regs.sv
// self-checking bench for the switch global control bank
`timescale 1ns/10ps
module tb_switch_global_control_regs;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic s_spd = 1'b0, s_dup = 1'b1, s_flw = 1'b1, igmp = 1'b0, hing = 1'b0, ten = 1'b0;
  logic blk = 1'b0, ssrc = 1'b1;
  logic [4:0] lk = 5'h03;
  wire drp;
  wire [3:0] sel;
  logic [11:0] pvid = 12'h00A;
  wire cyc, we, ack, err, vlan, pre, snf, bp, hd, fl, s10, per;
  wire [31:0] adr, wdat, rdat;
  wire [4:0] egr;
  wire [11:0] vid;
  wire [10:0] thr;
  int error_cnt = 0;
  int tests_run = 0;
  initial forever #2 clk_i = ~clk_i;
  sgc_wb_host i_host (.clk_i(clk_i), .ack_i(ack), .err_i(err), .dat_i(rdat), .cyc_o(cyc),
    .we_o(we), .sel_o(sel), .adr_o(adr), .dat_o(wdat));
  sgc_global_ctrl #(.PERIOD_100_CYC(20), .PERIOD_10_CYC(200)) i_dut (.clk_i(clk_i),
    .rst_i(rst_i), .cyc_i(cyc), .stb_i(cyc), .we_i(we), .adr_i(adr), .sel_i(sel),
    .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .err_o(err), .speed_strap_pin_i(s_spd),
    .duplex_strap_pin_i(s_dup), .flow_ctrl_strap_pin_i(s_flw), .igmp_pkt_i(igmp),
    .host_ingress_i(hing), .lookup_ports_i(lk), .preamble_ports_i(5'h05), .pkt_vid_i(pvid),
    .port_vid_i({7'h09, lk}), .sniff_src_match_i(ssrc), .sniff_dst_match_i(igmp),
    .storm_block_i(blk), .storm_port_10m_i(ten), .vlan_en_o(vlan), .egress_ports_o(egr),
    .host_pretag_en_o(pre), .sniff_hit_o(snf), .host_bp_en_o(bp), .host_half_dup_o(hd),
    .host_flow_en_o(fl), .host_speed_10_o(s10), .vid_out_o(vid), .storm_thresh_o(thr),
    .storm_drop_o(drp), .storm_period_o(per));
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] idx, input logic [7:0] wd,
    input logic [7:0] exp, input logic [1:0] resp);
    logic [7:0] rd;
    logic [1:0] r;
    i_host.xfer(w, idx, wd, rd, r);
    chk("response", r, resp);
    if (r === 2'b00) print_verdict();
    if (!w) chk("read data", rd, exp);
  endtask
  task automatic fwd(input logic [7:0] m, input logic ig, input logic hi, input logic [4:0] e);
    acc(1'b1, 8'h05, m, 8'h00, 2'b01);
    igmp <= ig;
    hing <= hi;
    repeat (3) @(posedge clk_i);
    chk("egress", egr, e);
    chk("sniff", snf, m[0] ? (ssrc & ig) : (ssrc | ig));
  endtask
  // threshold of two blocks, so the third block in a window drops
  task automatic t_storm;
    int n;
    ten <= 1'b0;
    acc(1'b1, 8'h06, 8'h00, 8'h00, 2'b01);
    acc(1'b1, 8'h07, 8'h02, 8'h00, 2'b01);
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (per !== 1'b1 && n < 1000);
    chk("window start", per, 1'b1);
    blk <= 1'b1;
    repeat (5) @(posedge clk_i);
    blk <= 1'b0;
    @(posedge clk_i);
    chk("storm drop", drp, 1'b1);
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (per !== 1'b1 && n < 1000);
    chk("window end", per, 1'b1);
    chk("drop cleared", drp, 1'b0);
  endtask
  task automatic t_period(input logic tn, input int exp);
    int n;
    ten <= tn;
    repeat (2) begin
      n = 0;
      do begin
        @(posedge clk_i);
        n++;
      end while (per !== 1'b1 && n < 1000);
    end
    chk("period", n, exp);
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk("threshold", thr, 11'h04A);
    chk("strap bits", {hd, fl, s10}, 3'b110);
    acc(1'b0, 8'h05, 8'h00, 8'h00, 2'b01);
    acc(1'b0, 8'h06, 8'h00, 8'h60, 2'b01);
    acc(1'b0, 8'h07, 8'h00, 8'h4A, 2'b01);
    $display("reset test done");
    acc(1'b1, 8'h05, 8'hFF, 8'h00, 2'b01);
    acc(1'b0, 8'h05, 8'h00, 8'hF3, 2'b01);
    chk("vlan and pretag", {vlan, pre}, 2'b11);
    acc(1'b1, 8'h06, 8'hDD, 8'h00, 2'b01);
    acc(1'b0, 8'h06, 8'h00, 8'hDD, 2'b01);
    chk("link bits", {bp, hd, fl, s10}, 4'b1101);
    chk("threshold", thr, 11'h54A);
    acc(1'b1, 8'h08, 8'h55, 8'h00, 2'b01);
    acc(1'b0, 8'h08, 8'h00, 8'h00, 2'b01);
    acc(1'b0, 8'h09, 8'h00, 8'h00, 2'b10);
    $display("register test done");
    pvid <= 12'h000;
    repeat (3) @(posedge clk_i);
    chk("null vid", vid, 12'h123);
    pvid <= 12'h00A;
    fwd(8'h40, 1'b1, 1'b1, 5'h10);
    fwd(8'h20, 1'b0, 1'b1, 5'h05);
    fwd(8'h03, 1'b0, 1'b0, 5'h0A);
    fwd(8'h82, 1'b0, 1'b0, 5'h03);
    fwd(8'h00, 1'b1, 1'b0, 5'h03);
    ssrc <= 1'b0;
    fwd(8'h00, 1'b0, 1'b0, 5'h03);
    $display("forwarding test done");
    t_period(1'b0, 20);
    t_period(1'b1, 200);
    $display("storm period test done");
    t_storm();
    $display("storm drop test done");
    print_verdict();
  end
endmodule
bind sgc_global_ctrl sgc_global_ctrl_props i_props (.*);
